// ---- design/pft_pkg.sv ----
/*
 pft_pkg: register map, field positions, codes and timing constants
 for the fault, trigger and blanking block of one PWM generator.
 assumes a 50 MHz system clock and a byte-addressed AXI4-Lite bus.
*/
package pft_pkg;
    localparam logic [7:0] ADDR_FAULT_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TRIG_CMP = 8'h04;
    localparam logic [7:0] ADDR_BLANK_CTRL = 8'h08;
    localparam logic [7:0] ADDR_OVERRIDE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [15:0] FAULT_CTRL_RESET = 16'h0000;
    localparam logic [15:0] TRIG_CMP_RESET = 16'h0000;
    localparam logic [15:0] BLANK_CTRL_RESET = 16'h0000;
    localparam logic [1:0] OVERRIDE_RESET = 2'h0;
    localparam logic [15:0] FAULT_CTRL_MASK = 16'h1FFF;
    localparam logic [15:0] TRIG_CMP_MASK = 16'hFFF8;
    localparam logic [15:0] BLANK_CTRL_MASK = 16'hFFF8;
    localparam int FLT_MODE_LSB = 0;
    localparam int FLT_POL_BIT = 2;
    localparam int FLT_SRC_LSB = 3;
    localparam int CL_MODE_BIT = 7;
    localparam int CL_POL_BIT = 8;
    localparam int CL_SRC_LSB = 9;
    localparam int TRG_LSB = 3;
    localparam int LEB_LSB = 3;
    localparam int CL_LEB_BIT = 10;
    localparam int FLT_LEB_BIT = 11;
    localparam int LOW_FALL_BIT = 12;
    localparam int LOW_RISE_BIT = 13;
    localparam int HIGH_FALL_BIT = 14;
    localparam int HIGH_RISE_BIT = 15;
    localparam logic [1:0] FLT_MODE_CYCLE = 2'h1;
    localparam logic [1:0] FLT_MODE_OFF = 2'h3;
    localparam logic [3:0] SRC_SHARED_ONE = 4'h8;
    localparam logic [3:0] SRC_IND_TWO = 4'hD;
    localparam logic [3:0] SRC_IND_FOUR = 4'hF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_PERIOD_NS = 20;
    localparam int BLANK_STEP_NS = 8;
    localparam int BLANK_REM_W = 10;
    localparam logic [BLANK_REM_W-1:0] CLK_PERIOD_REM = BLANK_REM_W'(CLK_PERIOD_NS);
endpackage

// ---- design/pft_fault_trigger.sv ----
/*
 pft_fault_trigger: fault source select and override, current-limit
 detect, leading-edge blanking and trigger compare for one generator,
 with an AXI4-Lite register slave.
 assumes the generator supplies its raw outputs, time base and a
 cycle-start pulse, all synchronous to clk_sys.
*/
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
// How it works
// - codes 0 to 3 pick comparators 1 to 4; codes 4 to 7 pick nothing.
// - codes 8 to B pick shared faults, D and F independent faults; C, E nothing.
// - polarity bit set means the chosen fault is active low, else high.
// - fault mode 01: active fault forces both outputs to override data.
// - fault mode 11 ignores the fault; 00 and 10 are reserved, treated likewise.
// - trigger value in bits 15:3 matching the time base pulses the trigger.
// - a trigger value of zero never produces a trigger.
// - high-side rising edge starts blanking when its enable is set.
// - high-side falling edge starts blanking when its enable is set.
// - low-side rising edge starts blanking when its enable is set.
// - low-side falling edge starts blanking when its enable is set.
// - fault blanking enable masks the chosen fault while blanking runs.
// - limit blanking enable masks the chosen limit input while blanking runs.
// - blanking length is the duration field times 8 ns, rounded up to whole 20 ns clocks.
// - generator modes live in the time base; this block serves them all.
// - override bit 1 drives the high side, bit 0 the low side.
// - forced outputs hold until the next cycle starts.
`timescale 1ns/10ps
`default_nettype none
module pft_fault_trigger (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] comparatorIn,
    input wire logic shared_fault_one,
    input wire logic shared_fault_two,
    input wire logic shared_fault_three,
    input wire logic shared_fault_four,
    input wire logic independent_fault_two,
    input wire logic independent_fault_four,
    input wire logic [15:0] timeBase,
    input wire logic cycleStart,
    input wire logic genHighIn,
    input wire logic genLowIn,
    output logic high_side_output,
    output logic low_side_output,
    output logic faultActive,
    output logic limitActive,
    output logic adcTrigger
);
    // map a byte address to a register slot, 7 = unmapped
    function automatic logic [2:0] regSlot(input logic [7:0] addr);
        case (addr)
            pft_pkg::ADDR_FAULT_CTRL: regSlot = 3'h0;
            pft_pkg::ADDR_TRIG_CMP: regSlot = 3'h1;
            pft_pkg::ADDR_BLANK_CTRL: regSlot = 3'h2;
            pft_pkg::ADDR_OVERRIDE: regSlot = 3'h3;
            pft_pkg::ADDR_STATUS: regSlot = 3'h4;
            default: regSlot = 3'h7;
        endcase
    endfunction

    // polarity-corrected source; reserved codes never assert
    function automatic logic srcActive(input logic [3:0] code, input logic pol,
                                       input logic [3:0] cmp, input logic [3:0] shr,
                                       input logic [1:0] ind);
        logic raw;
        logic ok;
        raw = 1'b0;
        ok = 1'b1;
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3: raw = cmp[code[1:0]];
            4'h8, 4'h9, 4'hA, 4'hB: raw = shr[code[1:0]];
            pft_pkg::SRC_IND_TWO: raw = ind[0];
            pft_pkg::SRC_IND_FOUR: raw = ind[1];
            default: ok = 1'b0;
        endcase
        srcActive = ok & (raw ^ pol);
    endfunction

    logic [15:0] faultCtrl_ff, nxt_faultCtrl;
    logic [15:0] trigCmp_ff, nxt_trigCmp;
    logic [15:0] blankCtrl_ff, nxt_blankCtrl;
    logic [1:0] override_ff, nxt_override;
    logic awGot_ff, nxt_awGot, wGot_ff, nxt_wGot;
    logic [7:0] wAddr_ff, nxt_wAddr;
    logic [31:0] wData_ff, nxt_wData;
    logic [3:0] wStrb_ff, nxt_wStrb;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [15:0] wMerged;
    logic blanking;

    always_comb begin
        nxt_faultCtrl = faultCtrl_ff;
        nxt_trigCmp = trigCmp_ff;
        nxt_blankCtrl = blankCtrl_ff;
        nxt_override = override_ff;
        nxt_awGot = awGot_ff | (s_axi_awvalid & awready_ff);
        nxt_wGot = wGot_ff | (s_axi_wvalid & wready_ff);
        nxt_wAddr = (s_axi_awvalid & awready_ff) ? s_axi_awaddr : wAddr_ff;
        nxt_wData = (s_axi_wvalid & wready_ff) ? s_axi_wdata : wData_ff;
        nxt_wStrb = (s_axi_wvalid & wready_ff) ? s_axi_wstrb : wStrb_ff;
        nxt_bvalid = bvalid_ff & ~s_axi_bready;
        nxt_bresp = bresp_ff;
        wMerged = 16'h0000;
        // commit once address and data are both held; second beat arrives any order
        if (awGot_ff && wGot_ff && !bvalid_ff) begin
            nxt_awGot = 1'b0;
            nxt_wGot = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = pft_pkg::RESP_OKAY;
            case (regSlot(wAddr_ff))
                3'h0: wMerged = faultCtrl_ff;
                3'h1: wMerged = trigCmp_ff;
                3'h2: wMerged = blankCtrl_ff;
                3'h3: wMerged = {14'h0000, override_ff};
                3'h4: wMerged = 16'h0000;
                default: nxt_bresp = pft_pkg::RESP_SLVERR;
            endcase
            if (wStrb_ff[0]) wMerged[7:0] = wData_ff[7:0];
            if (wStrb_ff[1]) wMerged[15:8] = wData_ff[15:8];
            case (regSlot(wAddr_ff))
                3'h0: nxt_faultCtrl = wMerged & pft_pkg::FAULT_CTRL_MASK;
                3'h1: nxt_trigCmp = wMerged & pft_pkg::TRIG_CMP_MASK;
                3'h2: nxt_blankCtrl = wMerged & pft_pkg::BLANK_CTRL_MASK;
                3'h3: nxt_override = wMerged[1:0];
                default: nxt_override = override_ff;
            endcase
        end
        nxt_awready = ~nxt_awGot & ~nxt_bvalid;
        nxt_wready = ~nxt_wGot & ~nxt_bvalid;
        nxt_rvalid = rvalid_ff & ~s_axi_rready;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = pft_pkg::RESP_OKAY;
            case (regSlot(s_axi_araddr))
                3'h0: nxt_rdata = {16'h0000, faultCtrl_ff};
                3'h1: nxt_rdata = {16'h0000, trigCmp_ff};
                3'h2: nxt_rdata = {16'h0000, blankCtrl_ff};
                3'h3: nxt_rdata = {30'h00000000, override_ff};
                3'h4: nxt_rdata = {29'h00000000, limitActive, blanking, faultActive};
                default: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = pft_pkg::RESP_SLVERR;
                end
            endcase
        end
        nxt_arready = ~nxt_rvalid;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            faultCtrl_ff <= pft_pkg::FAULT_CTRL_RESET;
            trigCmp_ff <= pft_pkg::TRIG_CMP_RESET;
            blankCtrl_ff <= pft_pkg::BLANK_CTRL_RESET;
            override_ff <= pft_pkg::OVERRIDE_RESET;
            awGot_ff <= 1'b0;
            wGot_ff <= 1'b0;
            wAddr_ff <= 8'h00;
            wData_ff <= 32'h00000000;
            wStrb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= 2'h0;
            rdata_ff <= 32'h00000000;
        end else begin
            faultCtrl_ff <= nxt_faultCtrl;
            trigCmp_ff <= nxt_trigCmp;
            blankCtrl_ff <= nxt_blankCtrl;
            override_ff <= nxt_override;
            awGot_ff <= nxt_awGot;
            wGot_ff <= nxt_wGot;
            wAddr_ff <= nxt_wAddr;
            wData_ff <= nxt_wData;
            wStrb_ff <= nxt_wStrb;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    // field views
    logic [1:0] fltMode;
    logic [3:0] fault_source_select, clSrc;
    logic [6:0] lebField;
    logic [12:0] trgField;
    assign fltMode = faultCtrl_ff[pft_pkg::FLT_MODE_LSB +: 2];
    assign fault_source_select = faultCtrl_ff[pft_pkg::FLT_SRC_LSB +: 4];
    assign clSrc = faultCtrl_ff[pft_pkg::CL_SRC_LSB +: 4];
    assign lebField = blankCtrl_ff[pft_pkg::LEB_LSB +: 7];
    assign trgField = trigCmp_ff[pft_pkg::TRG_LSB +: 13];

    logic highPrev_ff, nxt_highPrev, lowPrev_ff, nxt_lowPrev;
    logic [pft_pkg::BLANK_REM_W-1:0] blankRem_ff, nxt_blankRem;
    logic faultHold_ff, nxt_faultHold, limit_ff, nxt_limit;
    logic highOut_ff, nxt_highOut, lowOut_ff, nxt_lowOut;
    logic matchPrev_ff, nxt_matchPrev, trig_ff, nxt_trig;
    logic blankStart, faultSeen, limitSeen, match;
    logic [3:0] sharedIn;

    assign sharedIn = {shared_fault_four, shared_fault_three, shared_fault_two, shared_fault_one};
    assign blanking = blankRem_ff != '0;

    always_comb begin
        nxt_highPrev = genHighIn;
        nxt_lowPrev = genLowIn;
        blankStart = (blankCtrl_ff[pft_pkg::HIGH_RISE_BIT] & genHighIn & ~highPrev_ff)
            | (blankCtrl_ff[pft_pkg::HIGH_FALL_BIT] & ~genHighIn & highPrev_ff)
            | (blankCtrl_ff[pft_pkg::LOW_RISE_BIT] & genLowIn & ~lowPrev_ff)
            | (blankCtrl_ff[pft_pkg::LOW_FALL_BIT] & ~genLowIn & lowPrev_ff);
        // remaining time kept in ns so 8 ns steps round up to whole clocks
        if (blankStart) begin
            nxt_blankRem = pft_pkg::BLANK_REM_W'(lebField) *
                pft_pkg::BLANK_REM_W'(pft_pkg::BLANK_STEP_NS);
        end else if (blankRem_ff > pft_pkg::CLK_PERIOD_REM) begin
            nxt_blankRem = blankRem_ff - pft_pkg::CLK_PERIOD_REM;
        end else begin
            nxt_blankRem = '0;
        end
        faultSeen = srcActive(fault_source_select, faultCtrl_ff[pft_pkg::FLT_POL_BIT], comparatorIn,
            sharedIn, {independent_fault_four, independent_fault_two})
            & ~(blankCtrl_ff[pft_pkg::FLT_LEB_BIT] & blanking);
        limitSeen = srcActive(clSrc, faultCtrl_ff[pft_pkg::CL_POL_BIT], comparatorIn,
            sharedIn, {independent_fault_four, independent_fault_two})
            & ~(blankCtrl_ff[pft_pkg::CL_LEB_BIT] & blanking);
        nxt_limit = faultCtrl_ff[pft_pkg::CL_MODE_BIT] & limitSeen;
        // only cycle mode acts; reserved modes behave as disabled
        nxt_faultHold = ((fltMode == pft_pkg::FLT_MODE_CYCLE) & faultSeen)
            | (faultHold_ff & ~cycleStart);
        nxt_highOut = nxt_faultHold ? override_ff[1] : genHighIn;
        nxt_lowOut = nxt_faultHold ? override_ff[0] : genLowIn;
        match = (trgField != 13'h0000) && (timeBase == {trgField, 3'h0});
        nxt_matchPrev = match;
        // one pulse per match even when the time base dwells on the value
        nxt_trig = match & ~matchPrev_ff;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            highPrev_ff <= 1'b0;
            lowPrev_ff <= 1'b0;
            blankRem_ff <= '0;
            faultHold_ff <= 1'b0;
            limit_ff <= 1'b0;
            highOut_ff <= 1'b0;
            lowOut_ff <= 1'b0;
            matchPrev_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else begin
            highPrev_ff <= nxt_highPrev;
            lowPrev_ff <= nxt_lowPrev;
            blankRem_ff <= nxt_blankRem;
            faultHold_ff <= nxt_faultHold;
            limit_ff <= nxt_limit;
            highOut_ff <= nxt_highOut;
            lowOut_ff <= nxt_lowOut;
            matchPrev_ff <= nxt_matchPrev;
            trig_ff <= nxt_trig;
        end
    end

    assign high_side_output = highOut_ff;
    assign low_side_output = lowOut_ff;
    assign faultActive = faultHold_ff;
    assign limitActive = limit_ff;
    assign adcTrigger = trig_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic cycMode, noFltBlank;
    assign cycMode = fltMode == pft_pkg::FLT_MODE_CYCLE;
    assign noFltBlank = !blankCtrl_ff[pft_pkg::FLT_LEB_BIT];

    property p_cmpRoute;
        cycMode && noFltBlank && fault_source_select < 4'h4 && !faultCtrl_ff[pft_pkg::FLT_POL_BIT]
            && comparatorIn[fault_source_select[1:0]] |=> faultActive;
    endproperty
    a_cmpRoute: assert property (p_cmpRoute) else $error("comparator fault missed");
    property p_reservedSrc;
        cycMode && fault_source_select == 4'hC && !faultActive |=> !faultActive;
    endproperty
    a_reservedSrc: assert property (p_reservedSrc) else $error("reserved source fired");
    property p_indFour;
        cycMode && noFltBlank && fault_source_select == pft_pkg::SRC_IND_FOUR
            && (independent_fault_four ^ faultCtrl_ff[pft_pkg::FLT_POL_BIT]) |=> faultActive;
    endproperty
    a_indFour: assert property (p_indFour) else $error("fault polarity or route wrong");
    property p_override;
        faultActive |-> high_side_output == $past(override_ff[1])
            && low_side_output == $past(override_ff[0]);
    endproperty
    a_override: assert property (p_override) else $error("override data not driven");
    property p_modeOff;
        fltMode != pft_pkg::FLT_MODE_CYCLE && !faultActive |=> !faultActive;
    endproperty
    a_modeOff: assert property (p_modeOff) else $error("fault acted while disabled");
    property p_holdCycle;
        faultActive && !cycleStart |=> faultActive;
    endproperty
    a_holdCycle: assert property (p_holdCycle) else $error("override released early");
    property p_trigger;
        trgField != 13'h0000 && timeBase == {trgField, 3'h0} && !matchPrev_ff |=> adcTrigger;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger missed on match");
    property p_noTrigZero;
        trgField == 13'h0000 |=> !adcTrigger;
    endproperty
    a_noTrigZero: assert property (p_noTrigZero) else $error("trigger with zero value");
    property p_highRise;
        blankCtrl_ff[pft_pkg::HIGH_RISE_BIT] && lebField != 7'h00 && $rose(genHighIn)
            |=> blanking;
    endproperty
    a_highRise: assert property (p_highRise) else $error("rise did not start blanking");
    property p_lowFall;
        blankCtrl_ff[pft_pkg::LOW_FALL_BIT] && lebField != 7'h00 && $fell(genLowIn)
            |=> blanking;
    endproperty
    a_lowFall: assert property (p_lowFall) else $error("low fall did not start blanking");
    sequence s_start5;
        blankStart && lebField == 7'h05;
    endsequence
    sequence s_quiet2;
        !blankStart [*2];
    endsequence
    property p_blankLen;
        s_start5 ##1 s_quiet2 |=> !blanking;
    endproperty
    a_blankLen: assert property (p_blankLen) else $error("blanking length wrong");
    property p_blankHold;
        s_start5 |=> blanking [*2];
    endproperty
    a_blankHold: assert property (p_blankHold) else $error("blanking ended early");
    property p_faultMask;
        cycMode && !noFltBlank && blanking && !faultActive |=> !faultActive;
    endproperty
    a_faultMask: assert property (p_faultMask) else $error("fault passed blanking");
    property p_limitMask;
        blankCtrl_ff[pft_pkg::CL_LEB_BIT] && blanking |=> !limitActive;
    endproperty
    a_limitMask: assert property (p_limitMask) else $error("limit passed blanking");
endmodule
`default_nettype wire

// ---- verification/pft_power_stage.sv ----
/*
 pft_power_stage: far side of one generator: time base, raw gate drive
 and the ADC trigger input, which counts trigger pulses.
 assumes the bench stops the time base between tests; manual levels
 then stand in for the gate drive.
*/
`timescale 1ns/10ps
`default_nettype none
module pft_power_stage #(
    parameter int PERIOD = 64
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic manHigh,
    input wire logic manLow,
    input wire logic adcTrigger,
    output logic [15:0] timeBase,
    output logic cycleStart,
    output logic genHighIn,
    output logic genLowIn,
    output logic [31:0] trigSeen
);
    // stopped base parks at zero, which only a zero trigger value matches, and zero never triggers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timeBase <= 16'h0000;
            trigSeen <= 32'h0;
        end else begin
            timeBase <= (run && timeBase != 16'(PERIOD - 1)) ? timeBase + 16'h1 : 16'h0;
            trigSeen <= trigSeen + {31'h0, adcTrigger};
        end
    end
    assign cycleStart = run && timeBase == 16'h0000;
    assign genHighIn = run ? timeBase < 16'(PERIOD / 2) : manHigh;
    assign genLowIn = run ? timeBase >= 16'(PERIOD / 2) : manLow;
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
/*
 tb_top: self-checking bench for pft_fault_trigger: AXI4-Lite master,
 integer reference model and the power-stage partner.
 assumes the design package and the partner are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
    localparam int PERIOD = 64;
    logic clk_sys, rst_n, run, manHigh, manLow, cycleStart, genHighIn, genLowIn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, trigSeen;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [9:0] faultVec;
    logic [15:0] timeBase;
    logic high_side_output, low_side_output, faultActive, limitActive, adcTrigger;
    int error_cnt, cmp_count;
    pft_fault_trigger u_pft_fault_trigger (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparatorIn(faultVec[3:0]),
        .shared_fault_one(faultVec[4]), .shared_fault_two(faultVec[5]),
        .shared_fault_three(faultVec[6]), .shared_fault_four(faultVec[7]),
        .independent_fault_two(faultVec[8]), .independent_fault_four(faultVec[9]), .timeBase,
        .cycleStart, .genHighIn, .genLowIn, .high_side_output, .low_side_output, .faultActive,
        .limitActive, .adcTrigger);
    pft_power_stage #(.PERIOD(PERIOD)) u_pft_power_stage (.clk_sys, .rst_n, .run, .manHigh,
        .manLow, .adcTrigger, .timeBase, .cycleStart, .genHighIn, .genLowIn, .trigSeen);
    task automatic summarize;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic hang;
        error_cnt++;
        $display("Error bus wait expected 1 seen 0");
        summarize();
    endtask
    task automatic wr(input int a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= 8'(a);
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) hang();
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task automatic rd(input int a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= 8'(a);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) hang();
        s_axi_rready <= 1'b0;
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask
    // reserved codes never assert, whatever the polarity
    function automatic logic expAct(input int code, input int pol, input logic [9:0] v);
        logic r;
        if (code < 4) r = v[code];
        else if (code >= 8 && code < 12) r = v[code - 4];
        else if (code == 13) r = v[8];
        else if (code == 15) r = v[9];
        else return 1'b0;
        return r ^ pol[0];
    endfunction
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        int i, e, c, code, pol, mode, ovr, d, bl, m;
        int addrQ[$], maskQ[$], trigQ[$];
        logic ex;
        logic [9:0] rv;
        logic [31:0] base;
        void'($urandom(32'h985C));
        {rst_n, run, manHigh, manLow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, faultVec} = 28'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        addrQ = '{pft_pkg::ADDR_FAULT_CTRL, pft_pkg::ADDR_TRIG_CMP, pft_pkg::ADDR_BLANK_CTRL};
        maskQ = '{16'h1FFF, 16'hFFF8, 16'hFFF8};
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (i = 0; i < 3; i++) begin
            rd(addrQ[i], 32'h0, pft_pkg::RESP_OKAY);
            wr(addrQ[i], 32'hFFFFFFFF, pft_pkg::RESP_OKAY);
            rd(addrQ[i], maskQ[i], pft_pkg::RESP_OKAY);
            wr(addrQ[i], 32'h0, pft_pkg::RESP_OKAY);
        end
        wr(8'h14, 32'hFFFF, pft_pkg::RESP_SLVERR);
        rd(8'h14, 32'h0, pft_pkg::RESP_SLVERR);
        for (i = 0; i < 64; i++) begin
            code = i % 16;
            pol = (i / 16) % 2;
            mode = (i < 32) ? 1 : $urandom % 4;
            ovr = $urandom % 4;
            rv = 10'($urandom);
            // fault mode off first, so a polarity flip cannot latch a stale fault
            wr(pft_pkg::ADDR_FAULT_CTRL, 3, pft_pkg::RESP_OKAY);
            faultVec <= pol ? 10'h3FF : 10'h000;
            wr(pft_pkg::ADDR_OVERRIDE, ovr, pft_pkg::RESP_OKAY);
            wr(pft_pkg::ADDR_FAULT_CTRL, code << 3 | pol << 2 | mode, pft_pkg::RESP_OKAY);
            @(posedge clk_sys);
            faultVec <= rv;
            ex = mode == 1 && expAct(code, pol, rv);
            repeat (2) @(posedge clk_sys);
            #1;
            `CHK("faultActive", ex, faultActive)
            `CHK("outputs", ex ? 2'(ovr) : 2'h0, {high_side_output, low_side_output})
            @(posedge clk_sys);
            faultVec <= pol ? 10'h3FF : 10'h000;
            repeat (3) @(posedge clk_sys);
            #1;
            `CHK("held", ex, faultActive)
            @(posedge clk_sys);
            run <= 1'b1;
            @(posedge clk_sys);
            run <= 1'b0;
            repeat (2) @(posedge clk_sys);
            #1;
            `CHK("cleared", 1'b0, faultActive)
        end
        // values kept at zero or at least 8, as software must
        trigQ = '{0, 8, 'h2F, 'h40, (1 + $urandom % 7) * 8};
        foreach (trigQ[i]) begin
            wr(pft_pkg::ADDR_TRIG_CMP, trigQ[i], pft_pkg::RESP_OKAY);
            base = trigSeen;
            @(posedge clk_sys);
            run <= 1'b1;
            repeat (4 * PERIOD) @(posedge clk_sys);
            run <= 1'b0;
            repeat (3) @(posedge clk_sys);
            #1;
            m = trigQ[i] & 'hFFF8;
            `CHK("triggers", (m != 0 && m < PERIOD) ? 4 : 0, trigSeen - base)
        end
        wr(pft_pkg::ADDR_FAULT_CTRL, 'h81, pft_pkg::RESP_OKAY);
        for (e = 0; e < 4; e++) for (c = 0; c < 3; c++) begin
            d = (c == 2) ? 5 : 1 + $urandom % 20;
            bl = (d * pft_pkg::BLANK_STEP_NS + pft_pkg::CLK_PERIOD_NS - 1) / pft_pkg::CLK_PERIOD_NS;
            @(posedge clk_sys);
            faultVec <= 10'h000;
            manHigh <= e < 2 && e % 2;
            manLow <= e >= 2 && e % 2;
            @(posedge clk_sys);
            run <= 1'b1;
            @(posedge clk_sys);
            run <= 1'b0;
            wr(pft_pkg::ADDR_BLANK_CTRL, ((c == 1) ? ~(1 << (15 - e)) & 'hF000 : 1 << (15 - e))
                | (c == 0) << 11 | (c != 1) << 10 | d << 3, pft_pkg::RESP_OKAY);
            repeat (10) @(posedge clk_sys);
            if (e < 2) manHigh <= !manHigh;
            else manLow <= !manLow;
            @(posedge clk_sys);
            faultVec <= 10'h001;
            repeat (bl) @(posedge clk_sys);
            #1;
            `CHK("fault blanked", c != 0, faultActive)
            `CHK("limit blanked", c == 1, limitActive)
            @(posedge clk_sys);
            #1;
            `CHK("fault after", 1'b1, faultActive)
            `CHK("limit after", 1'b1, limitActive)
            rd(pft_pkg::ADDR_STATUS, 32'h5, pft_pkg::RESP_OKAY);
        end
        summarize();
    end
endmodule
`default_nettype wire
